// ==== card_uart_consts.vh ====
`ifndef CARD_UART_CONSTS_VH
`define CARD_UART_CONSTS_VH
// register indices on the apb window (byte address = index * 4)
`define IDX_MODEM_STATUS 3'd0
`define IDX_MODEM_CONTROL 3'd1
`define IDX_FIFO_CONTROL 3'd2
`define IDX_IRQ_ENABLE 3'd3
`define IDX_HOST_CFG 3'd4
`define IDX_HOST_DATA 3'd5
// modem status fields
`define MS_DCTS 0
`define MS_DDSR 1
`define MS_DDCD 3
`define MS_CTS 4
`define MS_DSR 5
`define MS_DCD 7
// modem control, fifo control, enable and host config fields
`define MC_DTR 0
`define MC_LOOP 4
`define FC_AUTO_RTS 4
`define FC_EXT 5
`define IE_MODEM 3
`define HC_COM_MAP 0
// reset values
`define RST_MODEM_CONTROL 8'h00
`define RST_FIFO_CONTROL 8'h00
`define RST_IRQ_ENABLE 8'h00
`define RST_HOST_CFG 8'h00
// fifo depths
`define DEPTH_STD 7'h10
`define DEPTH_EXT 7'h40
// base of the standard serial port window on the 10-bit host bus
`define COM_BASE 10'h3f8
`endif

// ==== sync2.v ====
`default_nettype none
module sync2 #(
	parameter W = 1
) (
	input wire i_ref_clk,
	input wire i_rstn,
	input wire [W-1:0] i_d,
	output reg [W-1:0] o_q
);
	reg [W-1:0] meta_r;
	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_r <= {W{1'b1}};
			o_q <= {W{1'b1}};
		end else begin
			meta_r <= i_d;
			o_q <= meta_r;
		end
	end
endmodule // sync2
`default_nettype wire

// ==== card_uart_pins.v ====
// What this block does
// [RL1] msr bit 4 shows clear-to-send level
// [RL2] msr bit 0 flags cts change
// [RL3] modem interrupt on cts/dcd/dsr change
// [RL4] msr bit 7 shows carrier-detect level
// [RL5] msr bit 3 flags dcd change
// [RL6] msr bit 5 shows data-set-ready level
// [RL7] msr bit 1 flags dsr change
// [RL8] reading msr clears delta bits
// [RL9] dtr active while mcr bit 0 high
// [RL10] dtr inactive on reset, loopback, cleared bit
// [RL11] depth select high gives 16-entry fifos
// [RL12] depth low plus fcr bit5 gives 64
// [RL13] auto-rts needs depth low, fcr bit4
// [RL14] host address bits 1-8 select attribute memory
// [RL15] uart decode bits 0-2 or 0-9
// [RL16] 8-bit bidirectional host data bus
// [RL17] input acknowledge on decoded i/o read
// [RL18] host uses read and write strobes
// [RL19] transfer needs attribute select and card enable
// [RL20] interrupt request asserted when service needed
// [RL22] ce1 even bytes, ce2 odd bytes
// [RL23] master reset clears uart, unconfigures card
// [RL24] read with no delta withdraws interrupt
//
// The register addresses and the APB slave port are this design's own decisions.
`default_nettype none
`include "card_uart_consts.vh"
module card_uart_pins (
	input wire i_ref_clk,
	input wire i_rstn,
	input wire i_master_reset,
	// apb slave
	input wire i_psel,
	input wire i_penable,
	input wire i_pwrite,
	input wire [11:0] i_paddr,
	input wire [31:0] i_pwdata,
	output reg [31:0] o_prdata,
	output reg o_pready,
	output reg o_pslverr,
	// modem pins, active low, then active-high fifo control outputs
	input wire i_cts_n,
	input wire i_dsr_n,
	input wire i_dcd_n,
	output reg o_dtr_n,
	output reg o_auto_rts_en,
	output reg [6:0] o_fifo_depth,
	output reg o_rx_trig_scaled,
	// fifo depth select pin
	input wire i_fifo_depth_sel,
	// host pins
	input wire [9:0] i_host_addr_bus,
	input wire [7:0] i_host_data_bus_in,
	output reg [7:0] o_host_data_bus_out,
	output reg o_host_data_bus_oe,
	input wire i_ce1_n,
	input wire i_ce2_n,
	input wire i_attr_sel_n,
	input wire i_iord_n,
	input wire i_iowr_n,
	output reg o_inpack_n,
	output reg o_ireq_n,
	output reg [7:0] o_attr_index,
	output reg o_attr_sel_valid
);
	////////////////////////////////////////////////////////////////////////////////
	function [7:0] field8;
		input [31:0] w;
		begin
			field8 = w[7:0];
		end
	endfunction

	// the standard port window covers eight byte addresses, so only bits 9:3 take part
	localparam [9:0] com_base_w = `COM_BASE;

	function com_hit;
		input [9:0] a;
		begin
			com_hit = (a[9:3] == com_base_w[9:3]);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; all pins of one kind share a two-flop stage
	wire [2:0] modem_s;
	wire [5:0] strobes_s;
	wire [9:0] addr_s;
	wire [7:0] hdata_s;
	wire depth_s;
	sync2 #(.W(3)) u_sync_modem (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_d({i_dcd_n, i_dsr_n, i_cts_n}),
		.o_q(modem_s)
	);
	sync2 #(.W(6)) u_sync_strobe (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_d({i_master_reset, i_ce1_n, i_ce2_n, i_attr_sel_n, i_iord_n, i_iowr_n}),
		.o_q(strobes_s)
	);
	sync2 #(.W(10)) u_sync_addr (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_d(i_host_addr_bus),
		.o_q(addr_s)
	);
	sync2 #(.W(8)) u_sync_data (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_d(i_host_data_bus_in),
		.o_q(hdata_s)
	);
	sync2 #(.W(1)) u_sync_depth (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_d(i_fifo_depth_sel),
		.o_q(depth_s)
	);
	// master reset pin is active high; sync reset value 1 keeps it asserted
	// until the first two edges after release, which is harmless
	wire mrst = strobes_s[5];
	wire ce1_n_s = strobes_s[4];
	wire ce2_n_s = strobes_s[3];
	wire reg_n_s = strobes_s[2];
	wire iord_n_s = strobes_s[1];
	wire iowr_n_s = strobes_s[0];
	wire cts = ~modem_s[0];
	wire dsr = ~modem_s[1];
	wire dcd = ~modem_s[2];

	////////////////////////////////////////////////////////////////////////////////
	// registers
	reg [7:0] modem_control_reg_r;
	reg [7:0] fifo_control_reg_r;
	reg [7:0] irq_enable_r;
	reg [7:0] host_cfg_r;
	reg [2:0] modem_prev_r;
	reg dcts_r, ddsr_r, ddcd_r;
	reg [7:0] host_latch_r;
	reg rd_prev_r, wr_prev_r;

	wire apb_go = i_psel & i_penable;
	wire [2:0] apb_idx = i_paddr[4:2];
	wire apb_mapped = (i_paddr[11:5] == 7'h00) && (i_paddr[1:0] == 2'b00) &&
		(apb_idx <= `IDX_HOST_DATA);

	// card enables: ce1 takes even bytes, ce2 odd ones [RL22]
	wire ce_ok = (~ce1_n_s & ~addr_s[0]) | (~ce2_n_s & addr_s[0]);
	wire io_cyc = ~reg_n_s & ce_ok; // [RL19]
	wire addr_hit = host_cfg_r[`HC_COM_MAP] ? com_hit(addr_s) : 1'b1; // [RL15]
	wire [2:0] uart_off = addr_s[2:0]; // [RL15]
	wire host_rd = io_cyc & ~iord_n_s & addr_hit; // [RL18] [RL19]
	wire host_wr = io_cyc & ~iowr_n_s & addr_hit; // [RL18] [RL19]
	wire host_wr_edge = host_wr & wr_prev_r;
	wire host_msr_rd = host_rd & rd_prev_r & (uart_off == 3'd6);
	wire apb_msr_rd = apb_go & ~i_pwrite & (apb_idx == `IDX_MODEM_STATUS) & apb_mapped;
	wire msr_rd = apb_msr_rd | host_msr_rd;

	wire [2:0] modem_now = {dcd, dsr, cts};
	wire [2:0] chg = modem_now ^ modem_prev_r;
	// a change in the read cycle survives the clear
	wire dcts_nxt = chg[0] | (dcts_r & ~msr_rd); // [RL2] [RL8]
	wire ddsr_nxt = chg[1] | (ddsr_r & ~msr_rd); // [RL7] [RL8]
	wire ddcd_nxt = chg[2] | (ddcd_r & ~msr_rd); // [RL5] [RL8]

	wire [7:0] msr_val = {dcd, 1'b0, dsr, cts, ddcd_r, 1'b0, ddsr_r, dcts_r}; // [RL1] [RL4] [RL6]

	function [7:0] uart_read;
		input [2:0] off;
		begin
			case (off)
				3'd2: uart_read = fifo_control_reg_r;
				3'd1: uart_read = irq_enable_r;
				3'd4: uart_read = modem_control_reg_r;
				3'd6: uart_read = msr_val;
				default: uart_read = 8'h00;
			endcase
		end
	endfunction

	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			modem_control_reg_r <= `RST_MODEM_CONTROL;
			fifo_control_reg_r <= `RST_FIFO_CONTROL;
			irq_enable_r <= `RST_IRQ_ENABLE;
			host_cfg_r <= `RST_HOST_CFG;
			host_latch_r <= 8'h00;
		end else if (mrst) begin
			modem_control_reg_r <= `RST_MODEM_CONTROL; // [RL23]
			fifo_control_reg_r <= `RST_FIFO_CONTROL; // [RL23]
			irq_enable_r <= `RST_IRQ_ENABLE; // [RL23]
			host_cfg_r <= `RST_HOST_CFG; // [RL23]
			host_latch_r <= 8'h00;
		end else if (apb_go & i_pwrite & apb_mapped) begin
			case (apb_idx)
				`IDX_MODEM_CONTROL: modem_control_reg_r <= field8(i_pwdata);
				`IDX_FIFO_CONTROL: fifo_control_reg_r <= field8(i_pwdata);
				`IDX_IRQ_ENABLE: irq_enable_r <= field8(i_pwdata);
				`IDX_HOST_CFG: host_cfg_r <= field8(i_pwdata);
				default: host_latch_r <= host_latch_r;
			endcase
		end else if (host_wr_edge) begin
			// host writes over the 8-bit data bus [RL16]
			case (uart_off)
				3'd1: irq_enable_r <= hdata_s;
				3'd2: fifo_control_reg_r <= hdata_s;
				3'd4: modem_control_reg_r <= hdata_s;
				default: host_latch_r <= hdata_s;
			endcase
		end
	end

	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			modem_prev_r <= 3'b000;
			dcts_r <= 1'b0;
			ddsr_r <= 1'b0;
			ddcd_r <= 1'b0;
			rd_prev_r <= 1'b1;
			wr_prev_r <= 1'b1;
		end else begin
			modem_prev_r <= modem_now;
			dcts_r <= mrst ? 1'b0 : dcts_nxt;
			ddsr_r <= mrst ? 1'b0 : ddsr_nxt;
			ddcd_r <= mrst ? 1'b0 : ddcd_nxt;
			// rising-edge detect of the qualified strobes
			rd_prev_r <= ~host_rd;
			wr_prev_r <= ~host_wr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// apb answer: zero wait states, unmapped gives pslverr
	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_prdata <= 32'h0000_0000;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= i_psel & ~i_penable;
			o_pslverr <= i_psel & ~i_penable & ~apb_mapped;
			if (i_psel & ~i_penable & ~i_pwrite & apb_mapped) begin
				case (apb_idx)
					`IDX_MODEM_STATUS: o_prdata <= {24'h0, msr_val};
					`IDX_MODEM_CONTROL: o_prdata <= {24'h0, modem_control_reg_r};
					`IDX_FIFO_CONTROL: o_prdata <= {24'h0, fifo_control_reg_r};
					`IDX_IRQ_ENABLE: o_prdata <= {24'h0, irq_enable_r};
					`IDX_HOST_CFG: o_prdata <= {24'h0, host_cfg_r};
					default: o_prdata <= {24'h0, host_latch_r};
				endcase
			end else begin
				o_prdata <= 32'h0000_0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin outputs
	wire delta_any = dcts_nxt | ddsr_nxt | ddcd_nxt;
	wire ext_ok = ~depth_s;
	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_dtr_n <= 1'b1;
			o_auto_rts_en <= 1'b0;
			o_fifo_depth <= `DEPTH_STD;
			o_rx_trig_scaled <= 1'b0;
			o_host_data_bus_out <= 8'h00;
			o_host_data_bus_oe <= 1'b0;
			o_inpack_n <= 1'b1;
			o_ireq_n <= 1'b1;
			o_attr_index <= 8'h00;
			o_attr_sel_valid <= 1'b0;
		end else begin
			// loopback forces dtr off [RL9] [RL10]
			o_dtr_n <= mrst | ~modem_control_reg_r[`MC_DTR] |
				modem_control_reg_r[`MC_LOOP];
			o_auto_rts_en <= ext_ok & fifo_control_reg_r[`FC_AUTO_RTS] & ~mrst; // [RL13]
			if (ext_ok & fifo_control_reg_r[`FC_EXT] & ~mrst) begin
				o_fifo_depth <= `DEPTH_EXT; // [RL12]
				o_rx_trig_scaled <= 1'b1; // [RL12]
			end else begin
				o_fifo_depth <= `DEPTH_STD; // [RL11]
				o_rx_trig_scaled <= 1'b0;
			end
			o_host_data_bus_out <= uart_read(uart_off); // [RL16]
			o_host_data_bus_oe <= host_rd & ~mrst; // [RL16]
			o_inpack_n <= ~(host_rd & ~mrst); // [RL17]
			// delta set while enabled pulls ireq; cleared on read [RL3] [RL20] [RL24]
			o_ireq_n <= ~(delta_any & irq_enable_r[`IE_MODEM] & ~mrst);
			o_attr_index <= addr_s[8:1]; // [RL14]
			o_attr_sel_valid <= ~reg_n_s & ce_ok & iord_n_s & iowr_n_s; // [RL14]
		end
	end
endmodule // card_uart_pins
`default_nettype wire

// ==== card_uart_pins_sva.sv ====
`default_nettype none
module card_uart_pins_sva (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_cts_n,
	input wire logic o_dtr_n,
	input wire logic o_auto_rts_en,
	input wire logic [6:0] o_fifo_depth,
	input wire logic o_rx_trig_scaled,
	input wire logic i_fifo_depth_sel,
	input wire logic i_iord_n,
	input wire logic i_attr_sel_n,
	input wire logic o_inpack_n,
	input wire logic o_host_data_bus_oe,
	input wire logic o_ireq_n
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	logic wr_ok, ie_q;
	logic [7:0] mc_q;
	assign wr_ok = i_psel && i_penable && o_pready && i_pwrite;
	// shadow of control writes; host-side writes are not seen, so only apb ones are judged
	always @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ie_q <= 1'b0;
			mc_q <= 8'h00;
		end else begin
			if (wr_ok && i_paddr == 12'h00c)
				ie_q <= i_pwdata[3];
			if (wr_ok && i_paddr == 12'h004)
				mc_q <= i_pwdata[7:0];
		end
	end
	dtr_follow_a: assert property (wr_ok && i_paddr == 12'h004
		|-> ##2 o_dtr_n == !(mc_q[0] && !mc_q[4])) else $error("dtr wrong after write");
	depth_std_a: assert property (i_fifo_depth_sel [*5] |-> o_fifo_depth == 7'h10)
		else $error("depth not 16");
	rts_gate_a: assert property (i_fifo_depth_sel [*5] |-> !o_auto_rts_en)
		else $error("auto rts with depth pin high");
	trig_scale_a: assert property (o_rx_trig_scaled == (o_fifo_depth == 7'h40))
		else $error("trigger scaling mismatch");
	inpack_oe_a: assert property (!o_inpack_n |-> o_host_data_bus_oe)
		else $error("ack without drive");
	inpack_qual_a: assert property ($fell(o_inpack_n)
		|-> !$past(i_iord_n, 3) && !$past(i_attr_sel_n, 3)) else $error("ack unqualified");
	irq_raise_a: assert property ($changed(i_cts_n) && ie_q |-> ##[1:6] !o_ireq_n)
		else $error("no irq on cts change");
	irq_quiet_a: assert property (!ie_q [*3] |-> o_ireq_n)
		else $error("irq while disabled");
	err_ready_a: assert property (o_pslverr |-> o_pready) else $error("error without ready");
endmodule // card_uart_pins_sva
bind card_uart_pins card_uart_pins_sva u_card_uart_pins_sva (.i_ref_clk, .i_rstn, .i_psel,
	.i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr, .i_cts_n, .o_dtr_n,
	.o_auto_rts_en, .o_fifo_depth, .o_rx_trig_scaled, .i_fifo_depth_sel, .i_iord_n,
	.i_attr_sel_n, .o_inpack_n, .o_host_data_bus_oe, .o_ireq_n);
`default_nettype wire

// ==== modem_model.sv ====
`default_nettype none
module modem_model (
	input wire logic i_ref_clk,
	input wire logic [2:0] i_act,
	input wire logic i_drive,
	input wire logic [7:0] i_wdata,
	output logic o_cts_pin,
	output logic o_dsr_pin,
	output logic o_dcd_pin,
	output logic [7:0] o_hdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {o_cts_pin, o_dsr_pin, o_dcd_pin, o_hdata} = 11'h700;
	// an undriven host bus toggles so a stale byte never passes for read data
	always @(posedge i_ref_clk) begin
		{o_dcd_pin, o_dsr_pin, o_cts_pin} <= ~i_act;
		o_hdata <= i_drive ? i_wdata : ~o_hdata;
	end
endmodule // modem_model
`default_nettype wire

// ==== testbench.sv ====
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_ref_clk = 1'b0, i_rstn = 1'b0, i_master_reset = 1'b0, i_fifo_depth_sel = 1'b1;
	logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, hwr = 1'b0, err, ack;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0, rd;
	logic [9:0] i_host_addr_bus = 10'h000;
	logic i_ce1_n = 1'b1, i_ce2_n = 1'b1, i_attr_sel_n = 1'b1, i_iord_n = 1'b1, i_iowr_n = 1'b1;
	logic [2:0] act = 3'h0;
	logic [7:0] hwd = 8'h00, hpat, hdat;
	wire [31:0] o_prdata;
	wire [6:0] o_fifo_depth;
	wire [7:0] o_host_data_bus_out, o_attr_index;
	wire o_pready, o_pslverr, o_dtr_n, o_auto_rts_en, o_rx_trig_scaled, o_host_data_bus_oe;
	wire o_inpack_n, o_ireq_n, o_attr_sel_valid, i_cts_n, i_dsr_n, i_dcd_n;
	wire [7:0] i_host_data_bus_in = o_host_data_bus_oe ? o_host_data_bus_out : hpat;
	int bad_count = 0, checks_done = 0;
	// rows: {dcd, dsr, cts active} then expected status byte without ring bits
	logic [10:0] rows [4] = '{11'h111, 11'h332, 11'h7b8, 11'h00b};
	card_uart_pins u_card_uart_pins (.*);
	modem_model u_modem_model (.i_ref_clk, .i_act(act), .i_drive(hwr), .i_wdata(hwd),
		.o_cts_pin(i_cts_n), .o_dsr_pin(i_dsr_n), .o_dcd_pin(i_dcd_n), .o_hdata(hpat));
	always #50 i_ref_clk = ~i_ref_clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge i_ref_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_ref_clk);
		i_penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_ref_clk);
			n++;
		end while (o_pready !== 1'b1 && n < 50);
		if (o_pready !== 1'b1) begin
			bad_count++;
			$display("CHECK FAILED at %0t: no ready from register bus", $time);
		end
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	// q is {attr select, ce2, ce1}, all active low
	task automatic hio(input logic r, input logic [9:0] a, input logic [2:0] q, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_host_addr_bus <= a;
		{i_attr_sel_n, i_ce2_n, i_ce1_n} <= q;
		hwd <= d;
		hwr <= !r;
		@(posedge i_ref_clk);
		i_iord_n <= !r;
		i_iowr_n <= r;
		repeat (5) @(posedge i_ref_clk);
		ack = o_inpack_n;
		hdat = o_host_data_bus_out;
		i_iord_n <= 1'b1;
		i_iowr_n <= 1'b1;
		@(posedge i_ref_clk);
		{i_attr_sel_n, i_ce2_n, i_ce1_n} <= 3'b111;
		hwr <= 1'b0;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		bad_count++;
		close_out();
	end
	initial begin
		repeat (20) @(posedge i_ref_clk);
		i_rstn <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		chk(o_dtr_n, 1'b1);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h040, 32'h0);
		chk(err, 1'b1);
		apb(1'b1, 12'h00c, 32'h8);
		for (int i = 0; i < 4; i++) begin
			act <= rows[i][10:8];
			repeat (6) @(posedge i_ref_clk);
			chk(o_ireq_n, 1'b0);
			apb(1'b0, 12'h000, 32'h0);
			chk(rd[7:0] & 8'hbb, rows[i][7:0]);
			repeat (2) @(posedge i_ref_clk);
			chk(o_ireq_n, 1'b1);
			apb(1'b0, 12'h000, 32'h0);
			chk(rd[7:0] & 8'h0b, 8'h00);
		end
		for (int i = 0; i < 4; i++) begin
			i_fifo_depth_sel <= i[1];
			apb(1'b1, 12'h008, i[0] ? 32'h30 : 32'h0);
			repeat (4) @(posedge i_ref_clk);
			chk(o_fifo_depth, (!i[1] && i[0]) ? 7'h40 : 7'h10);
			chk(o_auto_rts_en, !i[1] && i[0]);
		end
		hio(1'b1, 10'h006, 3'b010, 8'h00);
		chk(ack, 1'b0);
		hio(1'b1, 10'h002, 3'b010, 8'h00);
		chk(hdat, 8'h30);
		hio(1'b1, 10'h006, 3'b110, 8'h00);
		chk(ack, 1'b1);
		hio(1'b1, 10'h006, 3'b001, 8'h00);
		chk(ack, 1'b1);
		hio(1'b0, 10'h004, 3'b010, 8'h01);
		chk(o_dtr_n, 1'b0);
		apb(1'b1, 12'h004, 32'h11);
		repeat (2) @(posedge i_ref_clk);
		chk(o_dtr_n, 1'b1);
		apb(1'b1, 12'h010, 32'h1);
		hio(1'b1, 10'h3fe, 3'b010, 8'h00);
		chk(ack, 1'b0);
		chk(o_attr_index, 8'hff);
		apb(1'b1, 12'h004, 32'h1);
		repeat (2) @(posedge i_ref_clk);
		i_master_reset <= 1'b1;
		repeat (4) @(posedge i_ref_clk);
		i_master_reset <= 1'b0;
		repeat (4) @(posedge i_ref_clk);
		chk(o_dtr_n, 1'b1);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0);
		close_out();
	end
endmodule // testbench
`default_nettype wire
